/* core/hscp_port.sv */
// Host serial command port: SPI and I2C slave front end with load FIFO
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - SPI register write: address after mode bits, bytes MSB first, commit at last bit.
// - Writes to absent or read-only registers change nothing.
// - SPI register read shifts bytes out MSB first, address incrementing per byte.
// - Read of an absent register returns zero on SPI.
// - Byte FBh before a register access selects space B until select rises.
// - After FIFO read mode, successive FIFO bytes shift out while clocked.
// - Direct command is one byte, top bits 11, six-bit code, no arguments.
// - SPI direct command starts at the rising edge of select.
// - Host waits during long commands; device raises interrupt on completion.
// - Immediate command may be followed by another mode in same select period.
// - Passive target load stores from area start at consecutive locations.
// - I2C slave answers at fixed seven-bit address 50h.
// - I2C register write uses SPI write mode byte, incrementing addresses.
// - I2C register read returns incrementing registers, zero where absent.
// - I2C FIFO or passive target load stores the following data bytes.
// - I2C FIFO read supplies successive FIFO bytes while master reads.
// - I2C host waits during long commands; interrupt signals completion.
// - I2C space B byte after address holds space B until Stop.
// - Transparent command over I2C hands lines to the front end.
// - Select low then one clock pulse ends transparent mode.
// - First byte top bits decode write, read, FIFO/memory, command.
// - SPI mode 1: sample on falling edge, drive on rising, select low.
// - Passive target load areas start at locations 0, 15 and 36.

// ------------------------------------------------------------------
// Load FIFO
// ------------------------------------------------------------------
module hscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH-1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } hscp_fifo_st_t;

  hscp_fifo_st_t s;
  hscp_fifo_st_t n;
  logic          push;
  logic          pop;

  always_comb
  begin
    n = s;
    push = inValid && (s.count != CNT_FULL);
    pop = outReady && (s.count != '0);
    if (push)
    begin
      n.mem[s.wr] = inData;
      n.wr = (s.wr == PTR_LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop)
    begin
      n.rd = (s.rd == PTR_LAST) ? '0 : s.rd + 1'b1;
    end
    n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= n;
  end

  assign inReady = (s.count != CNT_FULL);
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rd];
endmodule

// ------------------------------------------------------------------
// Port engine
// ------------------------------------------------------------------
module hscp_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 i2cEnable,
  input  wire logic                 serialSelectN,
  input  wire logic                 sclk,
  input  wire logic                 mosi,
  input  wire logic                 sdaIn,
  output logic                      serialOut,
  output logic                      serialOe,
  output logic [5:0]                regAddr,
  output logic                      regSpaceB,
  input  wire logic [7:0]           regRdata,
  input  wire logic                 regExists,
  input  wire logic                 regWritable,
  output hscp_pkg::hscp_reg_wr_t    regWr,
  output hscp_pkg::hscp_ptm_wr_t    ptmWr,
  output logic                      fifoRdReq,
  input  wire logic [7:0]           fifoRdData,
  output logic                      fifoOutValid,
  input  wire logic                 fifoOutReady,
  output logic [7:0]                fifoOutData,
  output logic                      cmdStart,
  output logic [5:0]                cmdCode,
  input  wire logic                 cmdDone,
  output logic                      irq,
  output logic                      transparentMode,
  output logic                      loadOverflow
);

  typedef struct packed {
    logic [4:0]             syn1;
    logic [4:0]             syn2;
    logic [4:0]             prev;
    hscp_pkg::hscp_proc_t   proc;
    hscp_pkg::hscp_i2c_t    i2c;
    logic                   spaceB;
    logic [5:0]             addr;
    logic [hscp_pkg::PTM_AW-1:0] ptmAddr;
    logic                   cmdPend;
    logic [5:0]             cmdHeld;
    logic [7:0]             rxSh;
    logic [7:0]             txSh;
    logic [3:0]             cnt;
    logic                   rw;
    logic                   needTx;
    logic                   wrPend;
    logic [7:0]             wrData;
    logic                   outBit;
    logic                   outOe;
    hscp_pkg::hscp_reg_wr_t wr;
    hscp_pkg::hscp_ptm_wr_t ptm;
    logic                   push;
    logic [7:0]             pushData;
    logic                   fifoRd;
    logic                   cmdGo;
    logic [5:0]             cmdOut;
    logic                   irq;
    logic                   transp;
    logic                   ovf;
  } hscp_st_t;

  hscp_st_t s;
  hscp_st_t n;
  logic     pushReady;

  // Locals of the next-state logic
  logic       i2cMode;
  logic       ssn;
  logic       sclR;
  logic       sclF;
  logic       sclHigh;
  logic       sda;
  logic       rxV;
  logic [7:0] rxB;
  logic       txReq;
  logic       frameStart;
  logic       frameEnd;
  logic       readState;

  always_comb
  begin
    n = s;
    rxV = 1'b0;
    rxB = s.rxSh;
    txReq = 1'b0;
    frameStart = 1'b0;
    frameEnd = 1'b0;
    n.syn1 = {i2cEnable, serialSelectN, sclk, mosi, sdaIn};
    n.syn2 = s.syn1;
    n.prev = s.syn2;
    n.wr.write = 1'b0;
    n.ptm.write = 1'b0;
    n.push = 1'b0;
    n.fifoRd = 1'b0;
    n.cmdGo = 1'b0;
    n.needTx = 1'b0;
    i2cMode = s.syn2[hscp_pkg::SY_I2C];
    ssn = s.syn2[hscp_pkg::SY_SSN];
    sclR = s.syn2[hscp_pkg::SY_SCL] && !s.prev[hscp_pkg::SY_SCL];
    sclF = !s.syn2[hscp_pkg::SY_SCL] && s.prev[hscp_pkg::SY_SCL];
    sclHigh = s.syn2[hscp_pkg::SY_SCL] && s.prev[hscp_pkg::SY_SCL];
    sda = s.syn2[hscp_pkg::SY_SDA];
    readState = (s.proc == hscp_pkg::P_REG_RD) || (s.proc == hscp_pkg::P_FIFO_RD);

    // ----------------------------------------------------------------
    // SPI slave
    // ----------------------------------------------------------------
    if (!i2cMode)
    begin
      if (ssn && !s.prev[hscp_pkg::SY_SSN])
      begin
        frameEnd = 1'b1;
        n.outOe = 1'b0;
      end
      if (!ssn && s.prev[hscp_pkg::SY_SSN])
      begin
        frameStart = 1'b1;
        n.cnt = '0;
        n.outOe = 1'b0;
      end
      else if (!ssn)
      begin
        if (sclR)
        begin
          n.outBit = s.txSh[7];
          n.txSh = {s.txSh[6:0], 1'b0};
        end
        if (sclF)
        begin
          n.rxSh = {s.rxSh[6:0], s.syn2[hscp_pkg::SY_MOSI]};
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == hscp_pkg::BIT_LAST)
          begin
            rxV = 1'b1;
            rxB = {s.rxSh[6:0], s.syn2[hscp_pkg::SY_MOSI]};
            n.cnt = '0;
            n.needTx = 1'b1;
          end
        end
      end
      txReq = s.needTx;
    end
    // Transparent mode leaves the lines to the front end until released
    else if (s.transp)
    begin
      n.outOe = 1'b0;
      if (!ssn && sclR)
        n.transp = 1'b0;
    end
    // ----------------------------------------------------------------
    // I2C slave
    // ----------------------------------------------------------------
    else
    begin
      n.outBit = 1'b0;
      if (sclHigh && sda && !s.prev[hscp_pkg::SY_SDA])
      begin
        n.i2c = hscp_pkg::I_IDLE;
        n.outOe = 1'b0;
        frameEnd = 1'b1;
      end
      else if (sclHigh && !sda && s.prev[hscp_pkg::SY_SDA])
      begin
        // Repeated start keeps the byte processor state for reads
        n.i2c = hscp_pkg::I_ADDR;
        n.cnt = '0;
        n.outOe = 1'b0;
        frameStart = 1'b1;
      end
      else
      begin
        case (s.i2c)
          hscp_pkg::I_ADDR:
          begin
            if (sclR)
            begin
              n.rxSh = {s.rxSh[6:0], sda};
              n.cnt = s.cnt + 4'h1;
            end
            if (sclF && s.cnt == hscp_pkg::BIT_FULL)
            begin
              if (s.rxSh[7:1] == hscp_pkg::I2C_SLAVE_ADDR)
              begin
                n.outOe = 1'b1;
                n.rw = s.rxSh[0];
                n.i2c = hscp_pkg::I_ADDR_ACK;
                txReq = s.rxSh[0];
              end
              else
                n.i2c = hscp_pkg::I_IDLE;
            end
          end
          hscp_pkg::I_ADDR_ACK, hscp_pkg::I_TX_ACK:
          begin
            if (sclR && s.i2c == hscp_pkg::I_TX_ACK)
            begin
              if (sda)
                n.i2c = hscp_pkg::I_IDLE;
              else
                txReq = 1'b1;
            end
            if (sclF)
            begin
              n.cnt = '0;
              n.outOe = 1'b0;
              n.i2c = hscp_pkg::I_RX;
              if (s.rw)
              begin
                n.outOe = !s.txSh[7];
                n.txSh = {s.txSh[6:0], 1'b0};
                n.cnt = hscp_pkg::BIT_ONE;
                n.i2c = hscp_pkg::I_TX;
              end
            end
          end
          hscp_pkg::I_RX:
          begin
            if (sclR)
            begin
              n.rxSh = {s.rxSh[6:0], sda};
              n.cnt = s.cnt + 4'h1;
            end
            if (sclF && s.cnt == hscp_pkg::BIT_FULL)
            begin
              rxV = 1'b1;
              // A full FIFO refuses the byte with a NACK
              n.outOe = !(s.proc == hscp_pkg::P_FIFO_LD && !pushReady);
              n.i2c = hscp_pkg::I_RX_ACK;
            end
          end
          hscp_pkg::I_RX_ACK:
          begin
            if (sclF)
            begin
              n.outOe = 1'b0;
              n.cnt = '0;
              n.i2c = hscp_pkg::I_RX;
            end
          end
          hscp_pkg::I_TX:
          begin
            if (sclF)
            begin
              if (s.cnt == hscp_pkg::BIT_FULL)
              begin
                n.outOe = 1'b0;
                n.i2c = hscp_pkg::I_TX_ACK;
              end
              else
              begin
                n.outOe = !s.txSh[7];
                n.txSh = {s.txSh[6:0], 1'b0};
                n.cnt = s.cnt + 4'h1;
              end
            end
          end
          default:
            n.i2c = hscp_pkg::I_IDLE;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Frame boundaries
    // ----------------------------------------------------------------
    if (frameStart && !i2cMode)
    begin
      n.proc = hscp_pkg::P_MODE;
      n.cmdPend = 1'b0;
    end
    if (frameEnd)
    begin
      n.spaceB = 1'b0;
      n.proc = hscp_pkg::P_MODE;
      n.cmdPend = 1'b0;
      if (s.cmdPend)
      begin
        n.cmdGo = 1'b1;
        n.cmdOut = s.cmdHeld;
        if (i2cMode && s.cmdHeld == hscp_pkg::CMD_TRANSPARENT)
          n.transp = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Register write commit, one cycle after the byte so address is stable
    // ----------------------------------------------------------------
    if (s.wrPend)
    begin
      n.wrPend = 1'b0;
      n.wr.spaceB = s.spaceB;
      n.wr.addr = s.addr;
      n.wr.data = s.wrData;
      n.wr.write = regExists && regWritable;
      n.addr = s.addr + 6'h01;
    end

    // ----------------------------------------------------------------
    // Byte processor, shared by both links
    // ----------------------------------------------------------------
    if (rxV)
    begin
      case (s.proc)
        hscp_pkg::P_MODE:
        begin
          if (rxB == hscp_pkg::SPACE_B_BYTE)
            n.spaceB = 1'b1;
          else
          begin
            case (rxB[7:6])
              hscp_pkg::MODE_REG_WR:
              begin
                n.proc = hscp_pkg::P_REG_WR;
                n.addr = rxB[5:0];
              end
              hscp_pkg::MODE_REG_RD:
              begin
                n.proc = hscp_pkg::P_REG_RD;
                n.addr = rxB[5:0];
              end
              hscp_pkg::MODE_FIFO:
              begin
                case (rxB[5:0])
                  hscp_pkg::SUB_FIFO_LOAD: n.proc = hscp_pkg::P_FIFO_LD;
                  hscp_pkg::SUB_FIFO_READ: n.proc = hscp_pkg::P_FIFO_RD;
                  hscp_pkg::SUB_PTM_A:
                  begin
                    n.proc = hscp_pkg::P_PTM_LD;
                    n.ptmAddr = hscp_pkg::PTM_A_START;
                  end
                  hscp_pkg::SUB_PTM_F:
                  begin
                    n.proc = hscp_pkg::P_PTM_LD;
                    n.ptmAddr = hscp_pkg::PTM_F_START;
                  end
                  hscp_pkg::SUB_PTM_TSN:
                  begin
                    n.proc = hscp_pkg::P_PTM_LD;
                    n.ptmAddr = hscp_pkg::PTM_TSN_START;
                  end
                  default: n.proc = hscp_pkg::P_IGNORE;
                endcase
              end
              default:
              begin
                // Stay in mode decode so an immediate command can chain
                n.cmdPend = 1'b1;
                n.cmdHeld = rxB[5:0];
              end
            endcase
          end
        end
        hscp_pkg::P_REG_WR:
        begin
          n.wrPend = 1'b1;
          n.wrData = rxB;
        end
        hscp_pkg::P_FIFO_LD:
        begin
          n.push = 1'b1;
          n.pushData = rxB;
          if (!pushReady)
            n.ovf = 1'b1;
        end
        hscp_pkg::P_PTM_LD:
        begin
          // Overrun walks into the next area
          n.ptm.write = 1'b1;
          n.ptm.addr = s.ptmAddr;
          n.ptm.data = rxB;
          n.ptmAddr = s.ptmAddr + 1'b1;
        end
        default:
          n.proc = s.proc;
      endcase
    end

    if (txReq)
    begin
      case (s.proc)
        hscp_pkg::P_REG_RD:
        begin
          n.txSh = regExists ? regRdata : hscp_pkg::ZERO_BYTE;
          n.addr = s.addr + 6'h01;
        end
        hscp_pkg::P_FIFO_RD:
        begin
          n.txSh = fifoRdData;
          n.fifoRd = 1'b1;
        end
        default:
          n.txSh = hscp_pkg::IDLE_READ_BYTE;
      endcase
      if (!i2cMode)
        n.outOe = readState;
    end

    // Completion sets the interrupt even in the cycle a new access clears it
    n.irq = cmdDone || (s.irq && !frameStart);
    if (!i2cMode && frameStart)
      n.ovf = 1'b0;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.syn1 <= 5'h08;
      s.syn2 <= 5'h08;
      s.prev <= 5'h08;
    end
    else
      s <= n;
  end

  // ------------------------------------------------------------------
  // Load FIFO toward the core
  // ------------------------------------------------------------------
  hscp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .inValid  (s.push),
    .inReady  (pushReady),
    .inData   (s.pushData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  assign serialOut = s.outBit;
  assign serialOe = s.outOe;
  assign regAddr = s.addr;
  assign regSpaceB = s.spaceB;
  assign regWr = s.wr;
  assign ptmWr = s.ptm;
  assign fifoRdReq = s.fifoRd;
  assign cmdStart = s.cmdGo;
  assign cmdCode = s.cmdOut;
  assign irq = s.irq;
  assign transparentMode = s.transp;
  assign loadOverflow = s.ovf;
endmodule

`default_nettype wire

/* core/hscp_pkg.sv */
// Constants, states and carrier types of the host serial command port
package hscp_pkg;

  // ----------------------------------------------------------------
  // Byte codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_REG_WR   = 2'h0;
  localparam logic [1:0] MODE_REG_RD   = 2'h1;
  localparam logic [1:0] MODE_FIFO     = 2'h2;
  localparam logic [1:0] MODE_CMD      = 2'h3;
  localparam logic [7:0] SPACE_B_BYTE  = 8'hfb;
  localparam logic [5:0] SUB_FIFO_LOAD = 6'h00;
  localparam logic [5:0] SUB_PTM_A     = 6'h20;
  localparam logic [5:0] SUB_PTM_F     = 6'h28;
  localparam logic [5:0] SUB_PTM_TSN   = 6'h2c;
  localparam logic [5:0] SUB_FIFO_READ = 6'h1f;
  localparam logic [5:0] CMD_TRANSPARENT = 6'h1c;
  localparam logic [6:0] I2C_SLAVE_ADDR  = 7'h50;
  localparam logic [7:0] IDLE_READ_BYTE  = 8'hff;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // ----------------------------------------------------------------
  // Passive target memory layout
  // ----------------------------------------------------------------
  localparam int PTM_AW = 7;
  localparam logic [PTM_AW-1:0] PTM_A_START   = 7'h00;
  localparam logic [PTM_AW-1:0] PTM_F_START   = 7'h0f;
  localparam logic [PTM_AW-1:0] PTM_TSN_START = 7'h24;

  // ----------------------------------------------------------------
  // Bit counting
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;

  // Synchroniser lanes
  localparam int SY_I2C = 4;
  localparam int SY_SSN = 3;
  localparam int SY_SCL = 2;
  localparam int SY_MOSI = 1;
  localparam int SY_SDA = 0;

  // ----------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    P_MODE, P_REG_WR, P_REG_RD, P_FIFO_LD, P_PTM_LD, P_FIFO_RD, P_IGNORE
  } hscp_proc_t;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ADDR_ACK, I_RX, I_RX_ACK, I_TX, I_TX_ACK
  } hscp_i2c_t;

  typedef struct packed {
    logic       spaceB;
    logic [5:0] addr;
    logic [7:0] data;
    logic       write;
  } hscp_reg_wr_t;

  typedef struct packed {
    logic [PTM_AW-1:0] addr;
    logic [7:0]        data;
    logic              write;
  } hscp_ptm_wr_t;

endpackage

/* testbench/hscp_port_monitor.sv */
// Port checker: timing relations seen at the top module's ports
`timescale 1ns/100ps
`default_nettype none
module hscp_port_monitor (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire logic                   i2cEnable,
  input wire logic                   serialSelectN,
  input wire logic                   serialOe,
  input wire hscp_pkg::hscp_reg_wr_t regWr,
  input wire hscp_pkg::hscp_ptm_wr_t ptmWr,
  input wire logic                   fifoOutValid,
  input wire logic                   fifoOutReady,
  input wire logic [7:0]             fifoOutData,
  input wire logic                   cmdStart,
  input wire logic [5:0]             cmdCode,
  input wire logic                   cmdDone,
  input wire logic                   irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_cmd_on_rise: assert property (cmdStart |-> serialSelectN && $past(serialSelectN))
    else $error("command issued inside a frame");
  a_irq_set: assert property (cmdDone |=> irq)
    else $error("irq not raised on completion");
  a_irq_clear: assert property ((irq && !cmdDone && !i2cEnable && $fell(serialSelectN))
    |-> ##[1:6] !irq)
    else $error("irq not cleared at frame start");
  a_miso_idle: assert property ((!i2cEnable && serialSelectN) [*6] |-> !serialOe)
    else $error("output driven while deselected");
  a_wr_pulse: assert property (regWr.write |=> !regWr.write)
    else $error("register write longer than one cycle");
  a_ptm_pulse: assert property (ptmWr.write |=> !ptmWr.write)
    else $error("memory write longer than one cycle");
  a_code_hold: assert property (cmdStart |=> $stable(cmdCode) [*4])
    else $error("command code moved after issue");
  a_fifo_hold: assert property (fifoOutValid && !fifoOutReady
    |=> fifoOutValid && $stable(fifoOutData))
    else $error("stalled FIFO word changed");
endmodule
`default_nettype wire

/* testbench/hscp_host_model.sv */
// Host controller model: SPI master, polarity 0, phase 1
`timescale 1ns/100ps
`default_nettype none
module hscp_host_model (
  input  wire logic mclk,
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      serialSelectN
);
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    serialSelectN = 1'b1;
  end
  // Select fall opens a frame; first byte carries the mode
  task automatic sel();
    @(posedge mclk) serialSelectN <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // Data flips on release so a stale bit is never mistaken for a real one
  task automatic desel();
    repeat (6) @(posedge mclk);
    serialSelectN <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge mclk);
  endtask
  // Byte MSB first: driven on rise, sampled on fall, 400 ns period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk <= 1'b1;
      mosi <= tx[i];
      repeat (4) @(posedge mclk);
      rx[i] = miso;
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // I2C bit: data moves while the clock is low; mosi is the open-drain pull
  task automatic i2cBit(input logic b);
    sclk <= 1'b0;
    repeat (2) @(posedge mclk);
    mosi <= b;
    repeat (2) @(posedge mclk);
    sclk <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // Byte MSB first, then a released line for the slave's acknowledge
  task automatic i2cByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      i2cBit(b[i]);
    i2cBit(1'b1);
  endtask
  // Start and stop move data while the clock is high
  task automatic i2cStart();
    mosi <= 1'b1;
    sclk <= 1'b1;
    repeat (6) @(posedge mclk);
    mosi <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic i2cStop();
    i2cBit(1'b0);
    mosi <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_hscp_port.sv */
// Self-checking bench of the host serial command port in SPI and I2C mode
`timescale 1ns/100ps
`default_nettype none
module tb_hscp_port;
  logic mclk, arst_n, i2cEnable, sclk, mosi, ssn, sdaIn, serialOut, serialOe;
  logic regSpaceB, regExists, regWritable, fifoRdReq, fifoOutValid, fifoOutReady;
  logic cmdStart, cmdDone, irq, transparentMode, loadOverflow;
  logic [5:0] regAddr, cmdCode;
  logic [7:0] regRdata, fifoRdData, fifoOutData, rx;
  hscp_pkg::hscp_reg_wr_t regWr;
  hscp_pkg::hscp_ptm_wr_t ptmWr;
  logic [14:0] wrQ[$], ptmQ[$];
  logic [7:0] outQ[$];
  int nErrors, cmpCount, nStart;
  // SPI: undriven pad shows the inverse of its last bit; I2C: open drain, master on mosi
  assign sdaIn = i2cEnable ? (mosi && !serialOe) : (serialOe ? serialOut : ~serialOut);
  // Register model: 30h and above absent, 05h read-only
  assign regRdata = {2'h2, regAddr};
  assign regExists = regAddr < 6'h30;
  assign regWritable = regAddr != 6'h05;
  hscp_host_model host_u (.mclk, .miso(sdaIn), .sclk, .mosi, .serialSelectN(ssn));
  hscp_port dut_u (.mclk, .arst_n, .i2cEnable, .serialSelectN(ssn), .sclk, .mosi,
    .sdaIn, .serialOut, .serialOe, .regAddr, .regSpaceB, .regRdata, .regExists,
    .regWritable, .regWr, .ptmWr, .fifoRdReq, .fifoRdData, .fifoOutValid,
    .fifoOutReady, .fifoOutData, .cmdStart, .cmdCode, .cmdDone, .irq,
    .transparentMode, .loadOverflow);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (regWr.write) wrQ.push_back(regWr[15:1]);
    if (ptmWr.write) ptmQ.push_back(ptmWr[15:1]);
    if (fifoOutValid && fifoOutReady) outQ.push_back(fifoOutData);
    if (cmdStart) nStart++;
    if (fifoRdReq) fifoRdData <= fifoRdData + 8'h01;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sb(input logic [7:0] b);
    host_u.xfer(b, rx);
  endtask
  task automatic t_write();
    wrQ.delete();
    host_u.sel();
    sb(8'h03); sb(8'ha5); sb(8'h3c); sb(8'h77);
    host_u.desel();
    chk("wrCount", 16'h2, 16'(wrQ.size()));
    chk("wr0", {1'b0, 15'h03a5}, wrQ[0]);
    chk("wr1", {1'b0, 15'h043c}, wrQ[1]);
    $display("t_write done");
  endtask
  task automatic t_read();
    host_u.sel();
    sb(8'h6e);
    host_u.xfer(8'h00, rx); chk("rd2e", 16'h00ae, rx);
    host_u.xfer(8'h00, rx); chk("rd2f", 16'h00af, rx);
    host_u.xfer(8'h00, rx); chk("rd30", 16'h0000, rx);
    host_u.desel();
    chk("oeIdle", 16'h0, serialOe);
    $display("t_read done");
  endtask
  task automatic t_space();
    wrQ.delete();
    host_u.sel(); sb(8'hfb); sb(8'h01); sb(8'h11); host_u.desel();
    host_u.sel(); sb(8'h01); sb(8'h22); host_u.desel();
    chk("spB", {1'b0, 15'h4111}, wrQ[0]);
    chk("spA", {1'b0, 15'h0122}, wrQ[1]);
    $display("t_space done");
  endtask
  task automatic t_cmd();
    wrQ.delete();
    nStart = 0;
    host_u.sel(); sb(8'hd5); sb(8'h02); sb(8'h5a);
    chk("startEarly", 16'h0, 16'(nStart));
    host_u.desel();
    chk("startCount", 16'h1, 16'(nStart));
    chk("cmdCode", 16'h15, cmdCode);
    chk("chainWr", {1'b0, 15'h025a}, wrQ[0]);
    @(posedge mclk) cmdDone <= 1'b1;
    @(posedge mclk) cmdDone <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("irq", 16'h1, irq);
    $display("t_cmd done");
  endtask
  task automatic t_fifo();
    outQ.delete();
    host_u.sel(); sb(8'h80);
    for (int i = 0; i < 17; i++) sb(8'h10 + 8'(i));
    host_u.desel();
    chk("overflow", 16'h1, loadOverflow);
    @(posedge mclk) fifoOutReady <= 1'b1;
    // Bounded drain
    for (int k = 0; k < 100 && outQ.size() < 16; k++) @(posedge mclk);
    @(posedge mclk);
    chk("drained", 16'd16, 16'(outQ.size()));
    for (int i = 0; i < 16; i++) chk("fifoWord", 16'h10 + 16'(i), outQ[i]);
    chk("empty", 16'h0, fifoOutValid);
    fifoOutReady <= 1'b0;
    $display("t_fifo done");
  endtask
  task automatic t_fiford();
    logic [7:0] b;
    host_u.sel(); sb(8'h9f);
    b = fifoRdData;
    for (int i = 0; i < 3; i++)
    begin
      host_u.xfer(8'h00, rx);
      chk("fifoRd", b + 8'(i), rx);
    end
    host_u.desel();
    $display("t_fiford done");
  endtask
  task automatic t_ptm();
    logic [7:0] md[3] = '{8'ha0, 8'ha8, 8'hac};
    logic [6:0] st[3] = '{7'h00, 7'h0f, 7'h24};
    for (int m = 0; m < 3; m++)
    begin
      ptmQ.delete();
      host_u.sel(); sb(md[m]); sb(8'hc1); sb(8'hc2); host_u.desel();
      chk("ptm0", {1'b0, st[m], 8'hc1}, ptmQ[0]);
      chk("ptm1", {1'b0, st[m] + 7'h01, 8'hc2}, ptmQ[1]);
    end
    $display("t_ptm done");
  endtask
  task automatic t_i2c();
    wrQ.delete();
    i2cEnable <= 1'b1;
    host_u.i2cStart(); host_u.i2cByte(8'ha0); host_u.i2cByte(8'h05);
    host_u.i2cByte(8'h9c); host_u.i2cByte(8'h3e); host_u.i2cStop();
    chk("i2cWrCount", 16'h1, 16'(wrQ.size()));
    chk("i2cWr", {1'b0, 15'h063e}, wrQ[0]);
    $display("t_i2c done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    arst_n = 1'b0;
    i2cEnable = 1'b0;
    cmdDone = 1'b0;
    fifoOutReady = 1'b0;
    fifoRdData = 8'h40;
    nErrors = 0;
    cmpCount = 0;
    nStart = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_write(); t_read(); t_space(); t_cmd(); t_fifo(); t_fiford(); t_ptm();
    t_i2c();
    summarize();
  end
endmodule
bind hscp_port hscp_port_monitor mon_u (.mclk, .arst_n, .i2cEnable, .serialSelectN,
  .serialOe, .regWr, .ptmWr, .fifoOutValid, .fifoOutReady, .fifoOutData, .cmdStart,
  .cmdCode, .cmdDone, .irq);
`default_nettype wire
